// ---- design/audio_out_unit.sv ----
// Purpose: status, control, buffer switching and serial output of the
//   digital audio output unit
// Assumes: memory fetch port and register port on the processor clock
// Notes: memory bytes arrive with the byte at address a in bits 7:0
`timescale 1ns/10ps
module audio_out_unit (
	// clock and resets
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic core_reset,
	// register port
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [2:0] reg_idx,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// memory fetch
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	input wire logic fetch_ack,
	input wire logic [31:0] fetch_data,
	// chip power
	input wire logic chip_powerdown,
	output logic powered_down,
	// serial line and interrupt
	output logic serial_out,
	output logic irq
);
	import audio_out_pkg::*;

	unit_state_t s_reg;
	unit_state_t s_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic wr;
	logic [3:0] ack;
	logic halt;
	logic tick;
	logic [32:0] acc_sum;
	logic mode_ok;
	logic coded;
	logic word_end;
	logic [4:0] slot;
	logic [4:0] bidx;
	logic data_bit;
	logic [7:0] pre;
	logic [2:0] pidx;
	logic [31:0] swapped;
	logic [3:0] set_ev;
	logic drain_first;
	logic [31:0] fbase;
	logic [31:0] foff_inc;

	// write decode and acknowledge pulses
	assign wr = reg_sel & reg_wr;
	assign ack = (wr && reg_idx == REG_CONTROL) ?
		reg_wdata[CTL_ACK +: 4] : 4'h0;

	// powered down unless exempt
	assign halt = chip_powerdown & ~s_reg.exempt;

	// phase accumulator carry marks one unit interval
	assign acc_sum = {1'b0, s_reg.acc} + {1'b0, s_reg.rate};
	assign tick = acc_sum[32];

	// format decode
	assign coded = (s_reg.mode == MODE_CODED);
	assign mode_ok = coded || s_reg.mode == MODE_RAW_LSB ||
		s_reg.mode == MODE_RAW_MSB;

	// end of the word in the shifter
	assign word_end = s_reg.sh_valid & tick &
		(s_reg.ui == (coded ? UI_LAST_CODED : UI_LAST_RAW));

	// byte order of fetched words
	assign swapped = s_reg.little ? fetch_data :
		{fetch_data[7:0], fetch_data[15:8],
		fetch_data[23:16], fetch_data[31:24]};

	// buffer being fetched and next fetch offset
	assign fbase = s_reg.fsel ? s_reg.base2 : s_reg.base1;
	assign foff_inc = s_reg.foff + WORD_BYTES;

	// line level of the coded subframe and raw bit pick
	assign slot = s_reg.ui[5:1];
	assign pidx = s_reg.ui[2:0];
	assign bidx = (s_reg.mode == MODE_RAW_MSB) ?
		~s_reg.ui[4:0] : s_reg.ui[4:0];
	always_comb begin
		case (s_reg.sh_word[1:0])
			2'h0: pre = PRE_B;
			2'h1: pre = PRE_M;
			default: pre = PRE_W;
		endcase
		if (slot == PARITY_SLOT) begin
			data_bit = ^s_reg.sh_word[30:4];
		end else begin
			data_bit = s_reg.sh_word[slot];
		end
	end

	// drain of the buffer now on the line
	assign drain_first = s_reg.in_use;

	// the whole next state
	always_comb begin
		s_next = s_reg;
		set_ev = 4'h0;
		cnt_next = cnt_reg + 32'h00000001;
		// register writes
		if (wr) begin
			if (reg_idx == REG_CONTROL) begin
				s_next.inten = reg_wdata[CTL_INTEN +: 4];
				s_next.exempt = reg_wdata[CTL_EXEMPT];
				s_next.little = reg_wdata[CTL_LITTLE];
				s_next.mode = reg_wdata[CTL_MODE +: 3];
				s_next.run = reg_wdata[CTL_RUN];
			end else if (reg_idx == REG_RATE) begin
				s_next.rate = reg_wdata;
			end else if (reg_idx == REG_BASE1) begin
				s_next.base1 = reg_wdata;
			end else if (reg_idx == REG_BASE2) begin
				s_next.base2 = reg_wdata;
			end else if (reg_idx == REG_SIZE) begin
				s_next.size = reg_wdata;
			end
		end
		// a written one marks that buffer refilled
		if (ack[0]) begin
			s_next.ready[0] = 1'b1;
		end
		if (ack[1]) begin
			s_next.ready[1] = 1'b1;
		end
		if (!halt) begin
			s_next.acc = acc_sum[31:0];
			// fetch request toward memory
			if (!s_reg.fpend && !s_reg.stg_valid && s_reg.run &&
				mode_ok) begin
				s_next.fpend = 1'b1;
				s_next.faddr = fbase + s_reg.foff;
			end
			if (s_reg.fpend && fetch_ack) begin
				s_next.fpend = 1'b0;
				s_next.stg_word = swapped;
				s_next.stg_valid = 1'b1;
				s_next.stg_last = (foff_inc >= s_reg.size);
				if (foff_inc >= s_reg.size) begin
					s_next.foff = 32'h00000000;
					s_next.fsel = ~s_reg.fsel;
				end else begin
					s_next.foff = foff_inc;
				end
			end
			// unit interval stepping and line level
			if (s_reg.sh_valid && tick) begin
				s_next.ui = s_reg.ui + 6'h01;
				if (!coded) begin
					s_next.line = s_reg.sh_word[bidx];
				end else if (slot < PREAMBLE_SLOTS) begin
					if (s_reg.ui == 6'h00) begin
						s_next.pinv = s_reg.line;
						s_next.line = pre[7] ^ s_reg.line;
					end else begin
						s_next.line = pre[~pidx] ^ s_reg.pinv;
					end
				end else if (!s_reg.ui[0] || data_bit) begin
					s_next.line = ~s_reg.line;
				end
			end
			// word finished: buffer drain bookkeeping
			if (word_end && s_reg.sh_last) begin
				s_next.tstamp = cnt_reg;
				s_next.in_use = ~s_reg.in_use;
				if (drain_first) begin
					set_ev[0] = 1'b1;
					s_next.ready[0] = ack[0];
					set_ev[3] = ~(s_reg.ready[1] | ack[1]);
				end else begin
					set_ev[1] = 1'b1;
					s_next.ready[1] = ack[1];
					set_ev[3] = ~(s_reg.ready[0] | ack[0]);
				end
			end
			// next word into the shifter
			if (word_end || !s_reg.sh_valid) begin
				if (s_reg.run && mode_ok && s_reg.stg_valid) begin
					s_next.sh_word = s_reg.stg_word;
					s_next.sh_last = s_reg.stg_last;
					s_next.sh_valid = 1'b1;
					s_next.stg_valid = 1'b0;
					s_next.ui = 6'h00;
				end else begin
					s_next.sh_valid = 1'b0;
					set_ev[2] = word_end & s_reg.run;
				end
			end
		end
		// sticky flags, set wins over acknowledge
		s_next.flags = set_ev | (s_reg.flags & ~ack);
		// register read data
		if (reg_sel && !reg_wr) begin
			if (reg_idx == REG_STATUS) begin
				s_next.rdata = {27'h0, s_reg.in_use, s_reg.flags};
			end else if (reg_idx == REG_CONTROL) begin
				s_next.rdata = {18'h0, s_reg.run, s_reg.mode,
					s_reg.little, s_reg.exempt, s_reg.inten,
					4'h0};
			end else if (reg_idx == REG_RATE) begin
				s_next.rdata = s_reg.rate;
			end else if (reg_idx == REG_BASE1) begin
				s_next.rdata = s_reg.base1;
			end else if (reg_idx == REG_BASE2) begin
				s_next.rdata = s_reg.base2;
			end else if (reg_idx == REG_SIZE) begin
				s_next.rdata = s_reg.size;
			end else if (reg_idx == REG_TSTAMP) begin
				s_next.rdata = s_reg.tstamp;
			end else begin
				s_next.rdata = 32'h00000000;
			end
		end
		// soft reset cuts everything but the timestamp counter at once
		if (wr && reg_idx == REG_CONTROL && reg_wdata[CTL_SRST]) begin
			s_next = UNIT_RESET;
		end
	end

	// state registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_reg <= UNIT_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// timestamp counter follows the core cycle counter reset
	always_ff @(posedge ref_clk) begin
		if (rst || core_reset) begin
			cnt_reg <= 32'h00000000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// outputs
	assign reg_rdata = s_reg.rdata;
	assign fetch_req = s_reg.fpend;
	assign fetch_addr = s_reg.faddr;
	assign serial_out = s_reg.line;
	assign powered_down = halt;
	assign irq = |(s_reg.flags & s_reg.inten);
endmodule : audio_out_unit

// ---- design/audio_out_pkg.sv ----
// Purpose: constants and state type of the digital audio output unit
// Assumes: one processor clock, word-indexed register port
// Notes: register indices and control bit positions are local choices
// Summary of operation
// - one level interrupt output, interrupt source 25, vector offset 1008E4
// - interrupt high while any event flag and its enable are both set
// - event flags stay set until software writes one to their acknowledge, or rst or soft reset clears them
// - acknowledge removes the flag and its interrupt on the next cycle
// - 32-bit timestamp counter runs every cycle from the core reset
// - counter value caught when an emptied buffer's last bit leaves
// - buffer drained flags set on buffer end, cleared by acknowledge, rst or soft reset
// - bandwidth error set when staging runs dry before memory data arrives
// - starvation set when both buffers drain; switching still goes on
// - buffer-in-use reads one for first buffer, zero for second
// - acknowledge bits read zero; one clears flag, and bits 0 and 1 also mark their buffer refilled
// - powerdown exemption bit keeps the unit running in chip powerdown
// - byte-order bit selects little-endian word assembly, else big-endian
// - format 000 coded, 010 raw lsb first, 011 raw msb first
// - coded mode: biphase mark, preamble, parity, one subframe per word
// - run one starts output; run zero stops after the current word
// - soft reset bit resets all of the unit but the timestamp counter at once
// - rate setting drives the phase accumulator that makes unit intervals
// - two bases and one size; writing them leaves flags alone
// - timestamp register reads the catch for the last emptied buffer
// - little-endian word takes its top byte from a+3, low byte from a
// - coded frame lasts 128 unit intervals, two subframes of 64
// - after the second buffer drains, output returns to the first
// - rst and soft reset clear all fields except buffer-in-use and both ready bits, which come up set
package audio_out_pkg;
	localparam int IRQ_SOURCE = 25;
	localparam logic [31:0] IRQ_VECTOR_OFFSET = 32'h001008E4;
	// register indices
	localparam logic [2:0] REG_STATUS = 3'h0;
	localparam logic [2:0] REG_CONTROL = 3'h1;
	localparam logic [2:0] REG_RATE = 3'h2;
	localparam logic [2:0] REG_BASE1 = 3'h3;
	localparam logic [2:0] REG_BASE2 = 3'h4;
	localparam logic [2:0] REG_SIZE = 3'h5;
	localparam logic [2:0] REG_TSTAMP = 3'h6;
	// control and status bit positions
	localparam int CTL_ACK = 0;
	localparam int CTL_INTEN = 4;
	localparam int CTL_EXEMPT = 8;
	localparam int CTL_LITTLE = 9;
	localparam int CTL_MODE = 10;
	localparam int CTL_RUN = 13;
	localparam int CTL_SRST = 31;
	localparam int STS_IN_USE = 4;
	// format codes and coding constants
	localparam logic [2:0] MODE_CODED = 3'h0;
	localparam logic [2:0] MODE_RAW_LSB = 3'h2;
	localparam logic [2:0] MODE_RAW_MSB = 3'h3;
	localparam logic [5:0] UI_LAST_CODED = 6'h3F;
	localparam logic [5:0] UI_LAST_RAW = 6'h1F;
	localparam logic [4:0] PREAMBLE_SLOTS = 5'h04;
	localparam logic [4:0] PARITY_SLOT = 5'h1F;
	localparam logic [7:0] PRE_B = 8'hE8;
	localparam logic [7:0] PRE_M = 8'hE2;
	localparam logic [7:0] PRE_W = 8'hE4;
	localparam logic [31:0] WORD_BYTES = 32'h00000004;
	typedef struct packed {
		logic [3:0] flags; // drained1, drained2, bandwidth, starvation
		logic in_use;
		logic [1:0] ready;
		logic [3:0] inten;
		logic exempt;
		logic little;
		logic [2:0] mode;
		logic run;
		logic [31:0] rate;
		logic [31:0] base1;
		logic [31:0] base2;
		logic [31:0] size;
		logic [31:0] tstamp;
		logic [31:0] acc;
		logic fsel;
		logic [31:0] foff;
		logic fpend;
		logic [31:0] faddr;
		logic [31:0] stg_word;
		logic stg_valid;
		logic stg_last;
		logic [31:0] sh_word;
		logic sh_valid;
		logic sh_last;
		logic [5:0] ui;
		logic pinv;
		logic line;
		logic [31:0] rdata;
	} unit_state_t;
	// both buffers count as filled at start: software loads them first
	localparam unit_state_t UNIT_RESET = '{in_use: 1'b1, ready: 2'h3,
		default: '0};
endpackage : audio_out_pkg

// ---- tb/audio_out_properties.sv ----
// Purpose: port checks of the audio output unit
// Assumes: ports of audio_out_unit only
// Notes: soft reset writes are left out of the hold checks
`timescale 1ns/10ps
module audio_out_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register port
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [2:0] reg_idx,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// fetch, power and interrupt
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	input wire logic fetch_ack,
	input wire logic chip_powerdown,
	input wire logic powered_down,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic ctl_wr;
	logic srst;
	// control writes and soft reset writes
	assign ctl_wr = reg_sel && reg_wr && reg_idx == 3'h1;
	assign srst = ctl_wr && reg_wdata[31];
	AST_RST_QUIET: assert property ($fell(rst) |->
		!irq && !fetch_req && reg_rdata == 32'h0) else $error("reset");
	AST_PWR: assert property (!chip_powerdown |->
		!powered_down) else $error("powerdown");
	AST_ACK_IRQ: assert property (ctl_wr && reg_wdata[7:0] == 8'hFF
		|=> !irq) else $error("ack irq");
	AST_SRST: assert property (srst |=> !fetch_req && !irq)
		else $error("soft reset");
	AST_REQ_HOLD: assert property (fetch_req && !fetch_ack && !srst
		|=> fetch_req && $stable(fetch_addr)) else $error("req hold");
	AST_REQ_DROP: assert property (fetch_req && fetch_ack && !powered_down
		|=> !fetch_req) else $error("req drop");
	AST_RD_HOLD: assert property (!(reg_sel && !reg_wr) && !srst
		|=> $stable(reg_rdata)) else $error("read hold");
	AST_ACK_READ0: assert property (reg_sel && !reg_wr &&
		reg_idx == 3'h1 |=> reg_rdata[3:0] == 4'h0) else $error("ack read");
endmodule : audio_out_properties
bind audio_out_unit audio_out_properties chk (.ref_clk(ref_clk),
	.rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_idx(reg_idx),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fetch_req(fetch_req),
	.fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
	.chip_powerdown(chip_powerdown), .powered_down(powered_down),
	.irq(irq));

// ---- tb/audio_mem_model.sv ----
// Purpose: memory answering word fetches of the audio output unit
// Assumes: a request is held until acknowledged
// Notes: latency set by the bench; idle data toggles
`timescale 1ns/10ps
module audio_mem_model (
	// clock and latency
	input wire logic ref_clk,
	input wire logic [31:0] lat,
	// fetch port
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	output logic fetch_ack,
	output logic [31:0] fetch_data
);
	int n = 0;
	initial fetch_ack = 1'b0;
	initial fetch_data = 32'h0;
	// answer once after the latency, idle data never holds
	always @(negedge ref_clk) begin
		fetch_ack <= 1'b0;
		fetch_data <= ~fetch_data;
		n <= (fetch_req && !fetch_ack) ? n + 1 : 0;
		if (fetch_req && !fetch_ack && n >= lat) begin
			fetch_ack <= 1'b1;
			fetch_data <= {fetch_addr[15:0], ~fetch_addr[15:0]};
		end
	end
endmodule : audio_mem_model

// ---- tb/spdif_out_status_control_tb.sv ----
// Purpose: self-checking bench of the audio output unit
// Assumes: memory model answers after a set latency
// Notes: expected status words are worked out here
`timescale 1ns/10ps
module spdif_out_status_control_tb;
	import audio_out_pkg::*;
	logic ref_clk, rst, reg_sel, reg_wr, chip_powerdown, core_reset;
	logic [63:0] win = '0, exp_line = '0, hit_line = '0;
	logic fetch_req, fetch_ack, powered_down, serial_out, irq;
	logic [2:0] reg_idx;
	logic [31:0] reg_wdata, reg_rdata, fetch_addr, fetch_data, rd, ctl;
	logic [31:0] lat = 32'h2;
	int error_cnt = 0, checks = 0, seed = 32'h363d, cyc = 0, t0;
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// cycle count since reset, cleared by the core reset as well
	always @(posedge ref_clk) cyc <= (rst || core_reset) ? 0 : cyc + 1;
	audio_out_unit uut (.ref_clk(ref_clk), .rst(rst),
		.core_reset(core_reset),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_idx(reg_idx),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_ack(fetch_ack), .fetch_data(fetch_data),
		.chip_powerdown(chip_powerdown), .powered_down(powered_down),
		.serial_out(serial_out), .irq(irq));
	audio_mem_model mem (.ref_clk(ref_clk), .lat(lat),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_ack(fetch_ack), .fetch_data(fetch_data));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// line pattern of one raw word, two samples per unit interval
	function automatic logic [63:0] raw_line(input logic [31:0] w,
		input logic msb);
		logic [63:0] p;
		p = '0;
		for (int i = 0; i < 32; i++) begin
			p[2 * i +: 2] = {2{w[msb ? i : 31 - i]}};
		end
		return p;
	endfunction : raw_line
	// receiver: last 64 line samples, noted once the expected word passes
	always @(posedge ref_clk) begin
		win = {win[62:0], serial_out};
		if (win == exp_line) begin
			hit_line = win;
		end
	end
	// fetch order model: buffer one words, buffer two words, and again
	int m_off = 0, m_sel = 0;
	always @(posedge ref_clk) begin
		if (fetch_req && fetch_ack) begin
			check(fetch_addr, 'h100 * (1 + m_sel) + m_off);
			m_off = m_off + 4;
			if (m_off >= 8) begin
				m_off = 0;
				m_sel = 1 - m_sel;
			end
		end
		if (reg_sel && reg_wr && reg_idx == REG_CONTROL &&
			reg_wdata[CTL_SRST]) begin
			m_off = 0;
			m_sel = 0;
		end
	end
	// one register access, read data kept in rd
	task automatic acc(input logic w, input logic [2:0] i,
		input logic [31:0] d);
		@(negedge ref_clk);
		reg_sel = 1'b1;
		reg_wr = w;
		reg_idx = i;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_sel = 1'b0;
		rd = reg_rdata;
	endtask : acc
	// read status until all bits of m are set, bounded
	task automatic poll(input logic [31:0] m);
		int k;
		k = 0;
		do begin
			acc(1'b0, REG_STATUS, 32'h0);
			k++;
		end while ((rd & m) !== m && k < 2000);
		check(k < 2000, 1);
	endtask : poll
	// set up both buffers and start; w is the first word as sent
	task automatic start(input logic [31:0] c, input logic [31:0] w);
		acc(1'b1, REG_RATE, 32'h80000000);
		acc(1'b1, REG_BASE1, 32'h100);
		acc(1'b1, REG_BASE2, 32'h200);
		acc(1'b1, REG_SIZE, 32'h8);
		ctl = c; // format chosen while stopped
		exp_line = raw_line(w, c[CTL_MODE]);
		t0 = cyc;
		acc(1'b1, REG_CONTROL, ctl);
	endtask : start
	task automatic end_of_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		#400000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		{rst, reg_sel, reg_wr, reg_idx, reg_wdata, chip_powerdown} = '0;
		core_reset = 1'b0;
		rst = 1'b1;
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		// reset values of every index, the unmapped one too
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, i[2:0], 32'h0);
			check(rd, i == 0 ? 32'h10 : 32'h0);
		end
		for (int i = 2; i < 6; i++) begin
			ctl = $random(seed);
			acc(1'b1, i[2:0], ctl);
			acc(1'b0, i[2:0], 32'h0);
			check(rd, ctl);
		end
		acc(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h10);
		ctl = $random(seed) & 32'h1FF0;
		acc(1'b1, REG_CONTROL, ctl | 32'hF);
		acc(1'b0, REG_CONTROL, 32'h0);
		check(rd, ctl);
		chip_powerdown = 1'b1;
		acc(1'b1, REG_CONTROL, 32'h100);
		check(powered_down, 0);
		acc(1'b1, REG_CONTROL, 32'h0);
		check(powered_down, 1);
		chip_powerdown = 1'b0;
		$display("test registers done");
		// raw msb first, big-endian: bytes FF FE 00 01 at base one
		start(32'h00002CF0, 32'hFFFE0001);
		poll(32'h1);
		check(rd, 32'h1);
		check(irq, 1);
		check(hit_line == exp_line, 1);
		acc(1'b0, REG_TSTAMP, 32'h0);
		check(rd > t0 && rd <= cyc, 1);
		acc(1'b1, REG_CONTROL, ctl | 32'h1);
		check(irq, 0);
		poll(32'h2);
		check(rd, 32'h12);
		poll(32'h8);
		check(rd, 32'hB);
		acc(1'b1, REG_CONTROL, 32'hFF);
		check(irq, 0);
		$display("test buffers done");
		acc(1'b1, REG_CONTROL, 32'h80000000);
		acc(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h10);
		acc(1'b0, REG_CONTROL, 32'h0);
		check(rd, 32'h0);
		lat = 32'd300;
		// the core reset restarts the timestamp counter alone
		core_reset = 1'b1;
		@(negedge ref_clk);
		core_reset = 1'b0;
		// raw lsb first, little-endian: word as the memory holds it
		start(32'h00002AF0, 32'h0100FEFF);
		poll(32'h4);
		check(irq, 1);
		poll(32'h1);
		check(rd, 32'h5);
		acc(1'b0, REG_TSTAMP, 32'h0);
		check(rd > t0 && rd <= cyc, 1);
		check(hit_line == exp_line, 1);
		acc(1'b1, REG_CONTROL, 32'h80000000);
		$display("test bandwidth done");
		end_of_test();
	end
endmodule : spdif_out_status_control_tb
